/* File: iwd_cfg.svh */
`ifndef IWD_CFG_SVH
`define IWD_CFG_SVH

// ==========================================================
// Instruction word fields
`define IWD_MAJOR_MSB 5
`define IWD_MAJOR_LSB 0
`define IWD_FLD_A_MSB 31
`define IWD_FLD_A_LSB 27
`define IWD_FLD_B_MSB 26
`define IWD_FLD_B_LSB 22
`define IWD_FLD_C_MSB 21
`define IWD_FLD_C_LSB 17
`define IWD_SHORT_MSB 21
`define IWD_SHORT_LSB 6
`define IWD_EXT_MSB 16
`define IWD_EXT_LSB 6
`define IWD_LONG_MSB 31
`define IWD_LONG_LSB 6
// Within the class extension code: selector above, small immediate below
`define IWD_EXT_SEL_MSB 10
`define IWD_EXT_SEL_LSB 5
`define IWD_SMALL_MSB 4
`define IWD_SMALL_LSB 0

// ==========================================================
// Major class codes with a format of their own, and the link and zero register numbers
`define IWD_MAJOR_JUMP 6'h00
`define IWD_MAJOR_REG 6'h3a
`define IWD_RET_ADDR_REG 5'h1f
`define IWD_REG_ZERO 5'h00

// ==========================================================
// Register map (byte addresses) and reset values
`define IWD_AXI_AW 8
`define IWD_ADDR_WORD 8'h00
`define IWD_ADDR_CTRL 8'h04
`define IWD_ADDR_STATUS 8'h08
`define IWD_ADDR_RSVD_CNT 8'h0c
`define IWD_CTRL_SRC_BIT 0
`define IWD_WORD_RST 32'h0000_0000
`define IWD_CNT_RST 16'h0000
`define IWD_CNT_MAX 16'hffff
`define IWD_RESP_OKAY 2'b00
`define IWD_RESP_SLVERR 2'b10

`endif

/* File: iwd_pkg.sv */
package iwd_pkg;

  // ==========================================================
  // Operation identity: bit 6 marks register format, low six bits carry
  // the major class code (other formats) or the extension selector.
  typedef enum logic [6:0] {
    IWD_J_CALL = 7'h00, IWD_I_LDBU = 7'h03, IWD_I_ADDI = 7'h04, IWD_I_STB = 7'h05,
    IWD_I_BR = 7'h06, IWD_I_LDB = 7'h07, IWD_I_CMPGEI = 7'h08, IWD_I_LDHU = 7'h0b,
    IWD_I_ANDI = 7'h0c, IWD_I_STH = 7'h0d, IWD_I_BGE = 7'h0e, IWD_I_LDH = 7'h0f,
    IWD_I_CMPLTI = 7'h10, IWD_I_ORI = 7'h14, IWD_I_STW = 7'h15, IWD_I_BLT = 7'h16,
    IWD_I_LDW = 7'h17, IWD_I_CMPNEI = 7'h18, IWD_I_FLUSHDA = 7'h1b, IWD_I_XORI = 7'h1c,
    IWD_I_BNE = 7'h1e, IWD_I_CMPEQI = 7'h20, IWD_I_LDBUIO = 7'h23, IWD_I_MULI = 7'h24,
    IWD_I_STBIO = 7'h25, IWD_I_BEQ = 7'h26, IWD_I_LDBIO = 7'h27, IWD_I_CMPGEUI = 7'h28,
    IWD_I_LDHUIO = 7'h2b, IWD_I_ANDHI = 7'h2c, IWD_I_STHIO = 7'h2d, IWD_I_BGEU = 7'h2e,
    IWD_I_LDHIO = 7'h2f,
    IWD_R_ERET = 7'h41, IWD_R_ROLI = 7'h42, IWD_R_ROL = 7'h43, IWD_R_FLUSHP = 7'h44,
    IWD_R_RET = 7'h45, IWD_R_NOR = 7'h46, IWD_R_MULXUU = 7'h47, IWD_R_CMPGE = 7'h48,
    IWD_R_BRET = 7'h49, IWD_R_ROR = 7'h4b, IWD_R_FLUSHI = 7'h4c, IWD_R_JMP = 7'h4d,
    IWD_R_AND = 7'h4e, IWD_R_CMPLT = 7'h50, IWD_R_SLLI = 7'h52, IWD_R_SLL = 7'h53,
    IWD_R_OR = 7'h56, IWD_R_MULXSU = 7'h57, IWD_R_CMPNE = 7'h58, IWD_R_SRLI = 7'h5a,
    IWD_R_SRL = 7'h5b, IWD_R_NEXTPC = 7'h5c, IWD_R_CALLR = 7'h5d, IWD_R_XOR = 7'h5e,
    IWD_R_MULXSS = 7'h5f, IWD_R_CMPEQ = 7'h60, IWD_R_DIVU = 7'h64, IWD_R_DIV = 7'h65,
    IWD_R_RDCTL = 7'h66, IWD_R_MUL = 7'h67, IWD_R_CMPGEU = 7'h68, IWD_R_INITI = 7'h69,
    IWD_R_TRAP = 7'h6d, IWD_R_WRCTL = 7'h6e, IWD_R_CMPLTU = 7'h70, IWD_R_ADD = 7'h71,
    IWD_R_BREAK = 7'h74, IWD_R_SYNC = 7'h76, IWD_R_SUB = 7'h79, IWD_R_SRAI = 7'h7a,
    IWD_R_SRA = 7'h7b, IWD_RSVD = 7'h7f
  } iwd_oper_e;

  typedef enum logic [2:0] {
    IWD_FMT_JUMP = 3'b001,
    IWD_FMT_IMM = 3'b010,
    IWD_FMT_REG = 3'b100
  } iwd_fmt_e;

  // ==========================================================
  // Decoded word as handed to the execute datapath
  typedef struct packed {
    logic valid;
    logic reserved;
    iwd_fmt_e fmt;
    iwd_oper_e oper;
    logic [5:0] major_class_code;
    logic [10:0] class_extension_code;
    logic [4:0] reg_a;
    logic [4:0] reg_b;
    logic [4:0] reg_c;
    logic [4:0] src_a;
    logic [4:0] src_b;
    logic [4:0] dest;
    logic dest_we;
    logic opnd_b_imm;
    logic [15:0] short_immediate;
    logic [25:0] long_jump_immediate;
    logic [4:0] small_imm;
  } iwd_dec_s;

endpackage : iwd_pkg

/* File: iwd_decoder.sv */
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "iwd_cfg.svh"
// Operation
// - major class code from bits 5..0
// - immediate format fields A 31..27, B 26..22
// - short immediate from bits 21..6
// - register format A, B, C fields
// - extension code from bits 16..6
// - register format: A,B sources, C dest
// - some register ops use small extension immediate
// - long jump immediate from bits 31..6
// - code 0x00 is call, jump format
// - code 0x3a is register format, extension decides
// - other assigned codes are immediate format
// - unassigned codes decode as reserved, never valid
// - store and load major codes
// - conditional branch major codes
// - immediate logic, multiply and compare codes
// - multiply, divide, add, subtract extension codes
// - register compare extension codes
// - shift and rotate extension codes
// - control transfer extension codes
// - control register, sync, cache extension codes
// - bitwise, next-pc, high multiply extension codes
module iwd_decoder (
  input logic ref_clk_in,
  input logic sys_rst_in,
  input logic [31:0] fetch_word_in,
  input logic fetch_valid_in,
  output iwd_pkg::iwd_dec_s dec_out,
  output logic dec_valid_out,
  input logic [7:0] s_axi_awaddr_in,
  input logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input logic [31:0] s_axi_wdata_in,
  input logic [3:0] s_axi_wstrb_in,
  input logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input logic s_axi_bready_in,
  input logic [7:0] s_axi_araddr_in,
  input logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input logic s_axi_rready_in
);
  import iwd_pkg::*;

  // ==========================================================
  // Register bus: write path
  logic aw_full_r;
  logic w_full_r;
  logic aw_rdy_r;
  logic w_rdy_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [31:0] sw_word_r;
  logic src_sw_r;
  logic sw_go_r;

  // Address and data may land in either order; the response waits for both
  wire aw_take = s_axi_awvalid_in & aw_rdy_r;
  wire w_take = s_axi_wvalid_in & w_rdy_r;
  wire wr_done = aw_full_r & w_full_r & ~bvalid_r;
  wire aw_full_nxt = (aw_full_r | aw_take) & ~wr_done;
  wire w_full_nxt = (w_full_r | w_take) & ~wr_done;
  wire [7:0] wr_addr = {aw_addr_r[7:2], 2'b00};
  wire wr_word = wr_done & (wr_addr == `IWD_ADDR_WORD);
  wire wr_ctrl = wr_done & (wr_addr == `IWD_ADDR_CTRL);
  wire wr_known = wr_addr inside {`IWD_ADDR_WORD, `IWD_ADDR_CTRL, `IWD_ADDR_STATUS,
                                  `IWD_ADDR_RSVD_CNT};
  wire bvalid_nxt = wr_done | (bvalid_r & ~s_axi_bready_in);
  logic [31:0] sw_word_nxt;

  // Byte lanes of the software word follow the write strobes
  always_comb
  begin
    sw_word_nxt = sw_word_r;
    for (int i = 0; i < 4; i++)
    begin
      if (w_strb_r[i])
      begin
        sw_word_nxt[i*8 +: 8] = w_data_r[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_rdy_r <= 1'b1;
      w_rdy_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `IWD_RESP_OKAY;
      aw_addr_r <= `IWD_ADDR_WORD;
      w_data_r <= `IWD_WORD_RST;
      w_strb_r <= 4'h0;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      aw_rdy_r <= ~aw_full_nxt;
      w_rdy_r <= ~w_full_nxt;
      bvalid_r <= bvalid_nxt;
      if (wr_done)
      begin
        bresp_r <= wr_known ? `IWD_RESP_OKAY : `IWD_RESP_SLVERR;
      end
      if (aw_take)
      begin
        aw_addr_r <= s_axi_awaddr_in;
      end
      if (w_take)
      begin
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end
    end
  end

  // Software word and source select; a word write decodes only when selected
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      sw_word_r <= `IWD_WORD_RST;
      src_sw_r <= 1'b0;
      sw_go_r <= 1'b0;
    end
    else
    begin
      if (wr_word)
      begin
        sw_word_r <= sw_word_nxt;
      end
      if (wr_ctrl & w_strb_r[0])
      begin
        src_sw_r <= w_data_r[`IWD_CTRL_SRC_BIT];
      end
      sw_go_r <= wr_word & src_sw_r;
    end
  end

  // ==========================================================
  // Decode of one word
  // While software owns the decoder the fetch stream is ignored, so a bench
  // driving both sees only the software word decoded.
  wire [31:0] word = src_sw_r ? sw_word_r : fetch_word_in;
  wire take = src_sw_r ? sw_go_r : fetch_valid_in;

  wire [5:0] major_class_code = word[`IWD_MAJOR_MSB:`IWD_MAJOR_LSB];
  wire [4:0] fld_a = word[`IWD_FLD_A_MSB:`IWD_FLD_A_LSB];
  wire [4:0] fld_b = word[`IWD_FLD_B_MSB:`IWD_FLD_B_LSB];
  wire [4:0] fld_c = word[`IWD_FLD_C_MSB:`IWD_FLD_C_LSB];
  wire [15:0] short_immediate = word[`IWD_SHORT_MSB:`IWD_SHORT_LSB];
  wire [10:0] class_extension_code = word[`IWD_EXT_MSB:`IWD_EXT_LSB];
  wire [25:0] long_jump_immediate = word[`IWD_LONG_MSB:`IWD_LONG_LSB];
  wire [5:0] ext_sel = class_extension_code[`IWD_EXT_SEL_MSB:`IWD_EXT_SEL_LSB];
  wire [4:0] small_imm = class_extension_code[`IWD_SMALL_MSB:`IWD_SMALL_LSB];

  wire is_jump = (major_class_code == `IWD_MAJOR_JUMP);
  wire is_reg = (major_class_code == `IWD_MAJOR_REG);
  wire [6:0] cand = is_reg ? {1'b1, ext_sel} : {1'b0, major_class_code};

  // Membership in the encoding tables; anything else is reserved
  wire known = cand inside {
    IWD_J_CALL, IWD_I_LDBU, IWD_I_ADDI, IWD_I_STB, IWD_I_BR, IWD_I_LDB, IWD_I_CMPGEI,
    IWD_I_LDHU, IWD_I_ANDI, IWD_I_STH, IWD_I_BGE, IWD_I_LDH, IWD_I_CMPLTI, IWD_I_ORI,
    IWD_I_STW, IWD_I_BLT, IWD_I_LDW, IWD_I_CMPNEI, IWD_I_FLUSHDA, IWD_I_XORI, IWD_I_BNE,
    IWD_I_CMPEQI, IWD_I_LDBUIO, IWD_I_MULI, IWD_I_STBIO, IWD_I_BEQ, IWD_I_LDBIO,
    IWD_I_CMPGEUI, IWD_I_LDHUIO, IWD_I_ANDHI, IWD_I_STHIO, IWD_I_BGEU, IWD_I_LDHIO,
    IWD_R_ERET, IWD_R_ROLI, IWD_R_ROL, IWD_R_FLUSHP, IWD_R_RET, IWD_R_NOR,
    IWD_R_MULXUU, IWD_R_CMPGE, IWD_R_BRET, IWD_R_ROR, IWD_R_FLUSHI, IWD_R_JMP,
    IWD_R_AND, IWD_R_CMPLT, IWD_R_SLLI, IWD_R_SLL, IWD_R_OR, IWD_R_MULXSU,
    IWD_R_CMPNE, IWD_R_SRLI, IWD_R_SRL, IWD_R_NEXTPC, IWD_R_CALLR, IWD_R_XOR,
    IWD_R_MULXSS, IWD_R_CMPEQ, IWD_R_DIVU, IWD_R_DIV, IWD_R_RDCTL, IWD_R_MUL,
    IWD_R_CMPGEU, IWD_R_INITI, IWD_R_TRAP, IWD_R_WRCTL, IWD_R_CMPLTU, IWD_R_ADD,
    IWD_R_BREAK, IWD_R_SYNC, IWD_R_SUB, IWD_R_SRAI, IWD_R_SRA};
  wire iwd_oper_e oper = known ? iwd_oper_e'(cand) : IWD_RSVD;
  wire iwd_fmt_e fmt = is_jump ? IWD_FMT_JUMP : (is_reg ? IWD_FMT_REG : IWD_FMT_IMM);

  // Operations whose B field is read, not written
  wire b_is_src = oper inside {IWD_I_STB, IWD_I_STH, IWD_I_STW, IWD_I_STBIO, IWD_I_STHIO,
                               IWD_I_BR, IWD_I_BGE, IWD_I_BLT, IWD_I_BNE, IWD_I_BEQ,
                               IWD_I_BGEU, IWD_I_FLUSHDA};
  // Register operations that write no register
  wire r_no_dest = oper inside {IWD_R_ERET, IWD_R_BRET, IWD_R_RET, IWD_R_JMP, IWD_R_TRAP,
                                IWD_R_WRCTL, IWD_R_FLUSHP, IWD_R_FLUSHI, IWD_R_INITI,
                                IWD_R_SYNC, IWD_R_BREAK};
  wire r_small_opnd = oper inside {IWD_R_ROLI, IWD_R_SLLI, IWD_R_SRLI, IWD_R_SRAI};

  wire opnd_b_imm = is_reg ? r_small_opnd : (~is_jump & ~b_is_src);
  wire [4:0] src_b = is_reg ? fld_b : (b_is_src ? fld_b : `IWD_REG_ZERO);
  wire [4:0] dest = is_jump ? `IWD_RET_ADDR_REG : (is_reg ? fld_c : fld_b);
  wire dest_we = known & (is_jump | (is_reg ? ~r_no_dest : ~b_is_src));

  iwd_dec_s dec_nxt;
  assign dec_nxt = '{valid: known, reserved: ~known, fmt: fmt, oper: oper,
                     major_class_code: major_class_code,
                     class_extension_code: class_extension_code,
                     reg_a: fld_a, reg_b: fld_b, reg_c: fld_c,
                     src_a: is_jump ? `IWD_REG_ZERO : fld_a, src_b: src_b, dest: dest,
                     dest_we: dest_we, opnd_b_imm: opnd_b_imm,
                     short_immediate: short_immediate,
                     long_jump_immediate: long_jump_immediate, small_imm: small_imm};

  iwd_dec_s dec_r;
  logic dec_valid_r;
  logic [15:0] rsvd_cnt_r;
  // Saturates rather than wrapping, so a flood of bad words never reads as few
  wire [15:0] rsvd_cnt_nxt = (rsvd_cnt_r == `IWD_CNT_MAX) ? rsvd_cnt_r : rsvd_cnt_r + 16'h0001;

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      dec_r <= '0;
      dec_valid_r <= 1'b0;
      rsvd_cnt_r <= `IWD_CNT_RST;
    end
    else
    begin
      dec_valid_r <= take;
      if (take)
      begin
        dec_r <= dec_nxt;
      end
      if (take & ~known)
      begin
        rsvd_cnt_r <= rsvd_cnt_nxt;
      end
    end
  end

  // ==========================================================
  // Register bus: read path
  logic ar_rdy_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // Read data is captured at the address handshake and held until taken
  wire ar_take = s_axi_arvalid_in & ar_rdy_r;
  wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready_in);
  wire [7:0] rd_addr = {s_axi_araddr_in[7:2], 2'b00};
  wire [31:0] status_word = {16'h0000, dec_r.valid, dec_r.reserved, 2'b00, 1'b0, dec_r.fmt,
                             1'b0, dec_r.oper};
  wire [31:0] ctrl_word = {31'h0000_0000, src_sw_r};
  wire rd_known = rd_addr inside {`IWD_ADDR_WORD, `IWD_ADDR_CTRL, `IWD_ADDR_STATUS,
                                  `IWD_ADDR_RSVD_CNT};
  wire [31:0] rd_mux = (rd_addr == `IWD_ADDR_WORD) ? sw_word_r :
                       (rd_addr == `IWD_ADDR_CTRL) ? ctrl_word :
                       (rd_addr == `IWD_ADDR_STATUS) ? status_word :
                       (rd_addr == `IWD_ADDR_RSVD_CNT) ? {16'h0000, rsvd_cnt_r} :
                       `IWD_WORD_RST;

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= `IWD_WORD_RST;
      rresp_r <= `IWD_RESP_OKAY;
    end
    else
    begin
      ar_rdy_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take)
      begin
        rdata_r <= rd_mux;
        rresp_r <= rd_known ? `IWD_RESP_OKAY : `IWD_RESP_SLVERR;
      end
    end
  end

  assign dec_out = dec_r;
  assign dec_valid_out = dec_valid_r;
  assign s_axi_awready_out = aw_rdy_r;
  assign s_axi_wready_out = w_rdy_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = ar_rdy_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_major_field_taken: assert property (take |=> dec_out.major_class_code ==
    $past(word[`IWD_MAJOR_MSB:`IWD_MAJOR_LSB])) else $error("major class code wrong");
  a_imm_reg_fields: assert property (take && !is_reg && !is_jump |=>
    dec_out.reg_a == $past(fld_a) && dec_out.reg_b == $past(word[26:22]))
    else $error("immediate format register fields wrong");
  a_short_imm_field: assert property (take |=>
    dec_out.short_immediate == $past(word[21:6])) else $error("short immediate wrong");
  a_imm_operand_route: assert property (dec_valid_out && dec_out.fmt == IWD_FMT_IMM &&
    dec_out.valid && dec_out.opnd_b_imm |-> dec_out.src_a == dec_out.reg_a &&
    dec_out.dest == dec_out.reg_b && dec_out.dest_we) else $error("immediate routing wrong");
  a_reg_fields: assert property (take && is_reg |=> dec_out.reg_c == $past(word[21:17]) &&
    dec_out.class_extension_code == $past(word[16:6])) else $error("register fields wrong");
  a_reg_operand_route: assert property (dec_valid_out && dec_out.fmt == IWD_FMT_REG |->
    dec_out.src_a == dec_out.reg_a && dec_out.src_b == dec_out.reg_b &&
    dec_out.dest == dec_out.reg_c) else $error("register routing wrong");
  a_small_imm_use: assert property (dec_valid_out && dec_out.oper == IWD_R_SLLI |->
    dec_out.opnd_b_imm && dec_out.small_imm == dec_out.class_extension_code[4:0])
    else $error("small immediate not used");
  a_call_jump_fmt: assert property (take && word[5:0] == 6'h00 |=>
    dec_out.fmt == IWD_FMT_JUMP && dec_out.oper == IWD_J_CALL &&
    dec_out.long_jump_immediate == $past(word[31:6])) else $error("call decode wrong");
  a_reg_by_ext: assert property (take && word[5:0] == 6'h3a |=>
    dec_out.oper == {1'b1, $past(word[16:11])} || dec_out.reserved)
    else $error("register format not decided by extension");
  a_rsvd_never_valid: assert property (dec_valid_out && dec_out.reserved |->
    !dec_out.valid && dec_out.oper == IWD_RSVD && !dec_out.dest_we)
    else $error("reserved code decoded as valid");
  a_store_load_map: assert property (take && word[5:0] == 6'h15 ##1 dec_valid_out |->
    dec_out.oper == IWD_I_STW) else $error("store word mapping wrong");
  a_valid_one_cycle: assert property (take ##1 !take |=> !dec_valid_out)
    else $error("decode strobe held too long");
  a_bus_resp_once: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
    !s_axi_bvalid_out) else $error("write response repeated");
  a_ext_code_field: assert property (take |=>
    dec_out.class_extension_code == $past(word[16:6]))
    else $error("extension code wrong");
  a_long_imm_field: assert property (take |=>
    dec_out.long_jump_immediate == $past(word[31:6])) else $error("long immediate wrong");
  a_call_link_dest: assert property (dec_valid_out && dec_out.oper == IWD_J_CALL |->
    dec_out.dest == `IWD_RET_ADDR_REG && dec_out.dest_we) else $error("call link wrong");
  a_imm_fmt_rest: assert property (take && !is_reg && !is_jump |=>
    dec_out.fmt == IWD_FMT_IMM &&
    (dec_out.oper == {1'b0, $past(word[5:0])} || dec_out.reserved))
    else $error("immediate format not chosen");

  // ==========================================================
  // Encoding table spot checks
  a_load_byte_map: assert property (take && word[5:0] == 6'h27 |=>
    dec_out.oper == IWD_I_LDBIO) else $error("uncached load mapping wrong");
  a_branch_map: assert property (take && word[5:0] == 6'h2e |=>
    dec_out.oper == IWD_I_BGEU) else $error("branch mapping wrong");
  a_imm_logic_map: assert property (take && word[5:0] == 6'h2c |=>
    dec_out.oper == IWD_I_ANDHI) else $error("immediate logic mapping wrong");
  a_mul_div_map: assert property (take && is_reg && ext_sel == 6'h25 |=>
    dec_out.oper == IWD_R_DIV) else $error("divide mapping wrong");
  a_reg_cmp_map: assert property (take && is_reg && ext_sel == 6'h30 |=>
    dec_out.oper == IWD_R_CMPLTU) else $error("register compare mapping wrong");
  a_shift_map: assert property (take && is_reg && ext_sel == 6'h3a |=>
    dec_out.oper == IWD_R_SRAI && dec_out.opnd_b_imm) else $error("shift mapping wrong");
  a_ctl_xfer_map: assert property (take && is_reg && ext_sel == 6'h2d |=>
    dec_out.oper == IWD_R_TRAP && !dec_out.dest_we) else $error("trap mapping wrong");
  a_ctl_reg_map: assert property (take && is_reg && ext_sel == 6'h36 |=>
    dec_out.oper == IWD_R_SYNC) else $error("sync mapping wrong");
  a_bitwise_map: assert property (take && is_reg && ext_sel == 6'h06 |=>
    dec_out.oper == IWD_R_NOR) else $error("nor mapping wrong");

  c_reg_decoded: cover property (dec_valid_out && dec_out.fmt == IWD_FMT_REG && dec_out.valid);
  c_call_decoded: cover property (dec_valid_out && dec_out.oper == IWD_J_CALL);
  c_rsvd_seen: cover property (dec_valid_out && dec_out.reserved);
  c_sw_decode: cover property (sw_go_r ##1 dec_valid_out);
  c_imm_decoded: cover property (dec_valid_out && dec_out.fmt == IWD_FMT_IMM && dec_out.valid);

endmodule : iwd_decoder

/* File: iwd_fetch_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Fetch stage stand-in: one word per drive call
module iwd_fetch_model (
  input wire logic ref_clk_in,
  output logic [31:0] fetch_word_out,
  output logic fetch_valid_out
);
  initial
  begin
    fetch_word_out = 32'h0000_0000;
    fetch_valid_out = 1'b0;
  end

  task automatic drive(input logic [31:0] w);
    @(posedge ref_clk_in);
    fetch_word_out <= w;
    fetch_valid_out <= 1'b1;
  endtask : drive

  // Word lines flip while idle so a stale word never passes for a fresh one
  task automatic idle();
    @(posedge ref_clk_in);
    fetch_valid_out <= 1'b0;
    fetch_word_out <= ~fetch_word_out;
  endtask : idle
endmodule : iwd_fetch_model

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
  import iwd_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [31:0] fetch_word;
  logic fetch_valid;
  iwd_dec_s dec;
  logic dec_valid;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int compares = 0;
  logic [5:0] maj_tab [16] = '{6'h15, 6'h17, 6'h23, 6'h25, 6'h27, 6'h16, 6'h26, 6'h1e,
    6'h2e, 6'h14, 6'h24, 6'h1c, 6'h2c, 6'h10, 6'h18, 6'h20};
  logic [5:0] ext_tab [41] = '{6'h27, 6'h17, 6'h07, 6'h25, 6'h24, 6'h31, 6'h39, 6'h08,
    6'h18, 6'h28, 6'h10, 6'h20, 6'h30, 6'h02, 6'h12, 6'h1a, 6'h3a, 6'h03, 6'h13, 6'h1b,
    6'h3b, 6'h0b, 6'h0d, 6'h1d, 6'h2d, 6'h05, 6'h01, 6'h09, 6'h34, 6'h26, 6'h2e, 6'h36,
    6'h0c, 6'h29, 6'h04, 6'h0e, 6'h16, 6'h1e, 6'h06, 6'h1c, 6'h1f};

  always #25 ref_clk_in = ~ref_clk_in;

  iwd_fetch_model u_iwd_fetch_model (.ref_clk_in(ref_clk_in), .fetch_word_out(fetch_word),
    .fetch_valid_out(fetch_valid));

  iwd_decoder u_iwd_decoder (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .fetch_word_in(fetch_word), .fetch_valid_in(fetch_valid), .dec_out(dec),
    .dec_valid_out(dec_valid), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

  // ==========================================================
  // Shared helpers
  task automatic close_out();
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic dec_one(input logic [31:0] w);
    u_iwd_fetch_model.drive(w);
    u_iwd_fetch_model.idle();
    #1;
    cmp(dec_valid, 1'b1, "decode pulse");
  endtask : dec_one

  task automatic chk_id(input logic [2:0] f, input logic [6:0] o);
    cmp(dec.valid, 1'b1, "valid");
    cmp(dec.reserved, 1'b0, "reserved");
    cmp(dec.fmt, f, "format");
    cmp(dec.oper, o, "operation");
  endtask : chk_id

  // Write and read both wait for the answer; only the watchdog bounds them
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'bxx;
    while (1)
    begin
      @(posedge ref_clk_in);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1)
    begin
      @(posedge ref_clk_in);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  // ==========================================================
  // Scenarios
  task automatic t_imm();
    dec_one({5'h03, 5'h07, 16'hbeef, 6'h04});
    cmp(dec.major_class_code, 6'h04, "major code");
    cmp({dec.reg_a, dec.reg_b}, {5'h03, 5'h07}, "fields a b");
    cmp(dec.short_immediate, 16'hbeef, "short imm");
    cmp({dec.src_a, dec.dest, dec.opnd_b_imm}, {5'h03, 5'h07, 1'b1}, "imm route");
    chk_id(3'b010, 7'h04);
  endtask : t_imm

  // Register word, then a small-immediate shift and a call back to back
  task automatic t_reg_b2b();
    dec_one({5'h01, 5'h02, 5'h1d, 6'h31, 5'h15, 6'h3a});
    chk_id(3'b100, 7'h71);
    cmp({dec.reg_a, dec.reg_b, dec.reg_c}, {5'h01, 5'h02, 5'h1d}, "fields abc");
    cmp(dec.class_extension_code, {6'h31, 5'h15}, "ext code");
    cmp({dec.src_a, dec.src_b, dec.dest}, {5'h01, 5'h02, 5'h1d}, "reg route");
    cmp(dec.opnd_b_imm, 1'b0, "reg operand");
    u_iwd_fetch_model.drive({5'h04, 5'h00, 5'h05, 6'h12, 5'h0a, 6'h3a});
    u_iwd_fetch_model.drive({26'h2ab_cdef, 6'h00});
    #1;
    chk_id(3'b100, 7'h52);
    cmp({dec.opnd_b_imm, dec.small_imm}, {1'b1, 5'h0a}, "small imm");
    u_iwd_fetch_model.idle();
    #1;
    cmp(dec_valid, 1'b1, "second pulse");
    chk_id(3'b001, 7'h00);
    cmp(dec.long_jump_immediate, 26'h2ab_cdef, "long imm");
    @(posedge ref_clk_in);
    #1;
    cmp(dec_valid, 1'b0, "pulse ends");
  endtask : t_reg_b2b

  task automatic t_tables();
    foreach (maj_tab[i])
    begin
      dec_one({5'h11, 5'h12, 16'h1234, maj_tab[i]});
      chk_id(3'b010, {1'b0, maj_tab[i]});
    end
    foreach (ext_tab[i])
    begin
      dec_one({15'h0000, ext_tab[i], 5'h00, 6'h3a});
      chk_id(3'b100, {1'b1, ext_tab[i]});
    end
  endtask : t_tables

  task automatic t_rsvd();
    logic [31:0] words [3] = '{32'h0000_0001, 32'h0000_003b, 32'h0000_003a};
    foreach (words[i])
    begin
      dec_one(words[i]);
      cmp({dec.valid, dec.reserved, dec.oper}, {2'b01, 7'h7f}, "reserved");
    end
  endtask : t_rsvd

  // Software source: fetch words refused, WORD write decodes, register map read back
  task automatic t_sw();
    logic [1:0] r;
    logic [31:0] d;
    axi_write(8'h04, 32'h0000_0001, r);
    cmp(r, 2'b00, "ctrl write");
    u_iwd_fetch_model.drive(32'h0000_0001);
    u_iwd_fetch_model.idle();
    #1;
    cmp(dec_valid, 1'b0, "fetch refused");
    axi_write(8'h00, {15'h0000, 6'h20, 5'h00, 6'h3a}, r);
    #1;
    cmp(dec_valid, 1'b1, "software decode pulse");
    chk_id(3'b100, 7'h60);
    axi_read(8'h08, d, r);
    cmp(d, 32'h0000_8460, "status");
    axi_read(8'h0c, d, r);
    cmp(d, 32'h0000_0003, "reserved count");
    axi_read(8'h00, d, r);
    cmp(d, {15'h0000, 6'h20, 5'h00, 6'h3a}, "word readback");
    axi_read(8'h10, d, r);
    cmp({r, d}, {2'b10, 32'h0000_0000}, "unmapped read");
    axi_write(8'h10, 32'h0000_0000, r);
    cmp(r, 2'b10, "unmapped write");
    axi_write(8'h04, 32'h0000_0000, r);
    cmp(r, 2'b00, "ctrl release");
  endtask : t_sw

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (12) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    #1;
    cmp(32'(|dec), 32'h0000_0000, "dec at reset");
    cmp({dec_valid, bvalid, rvalid, awready, wready, arready}, 6'b000111, "reset outputs");
    t_imm();
    t_reg_b2b();
    t_tables();
    t_rsvd();
    t_sw();
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    close_out();
  end
endmodule : testbench
